// ---- bench/frame_grabber_model.sv ----
// Frame grabber model that accepts and logs rows
`timescale 1ns/10ps
module frame_grabber_model (
	// Clock and reset
	input  logic        ref_clk,
	input  logic        resetn,
	// Row stream
	input  logic        row_valid,
	output logic        row_ready,
	input  logic [11:0] row_addr,
	input  logic        row_top_group,
	input  logic        row_col_skip,
	input  logic        row_last,
	// Stall from the bench
	input  logic        stall
);
	logic [14:0] rows[$];
	assign row_ready = !stall;
	always @(posedge ref_clk) begin
		if (resetn && row_valid && row_ready)
			rows.push_back({row_last, row_col_skip, row_top_group, row_addr});
	end
endmodule // frame_grabber_model

// ---- bench/row_flip_subsample_sequencer_bench.sv ----
// Self-checking bench for the row sequencer
`timescale 1ns/10ps
`include "row_seq_consts.vh"
module row_flip_subsample_sequencer_bench;
	logic        ref_clk, resetn, cfg_wr, frame_start, stall, frame_busy, frame_done;
	logic        row_valid, row_ready, row_top_group, row_col_skip, row_last;
	logic [6:0]  cfg_addr;
	logic [15:0] cfg_wdata, cfg_rdata;
	logic [11:0] row_addr;
	int          miscompares = 0, check_count = 0;
	// Kind, skip, offset, step, mode, flip, lines
	int          tbl[8][7] = '{'{0,0,0,1,9,0,4}, '{0,0,0,1,9,2,4}, '{1,5,3,6,9,0,12}, '{1,9,5,10,9,0,4},
		'{2,6,0,4,0,0,6}, '{2,10,0,6,0,2,4}, '{1,1,1,2,11,0,4}, '{2,2,0,2,2,0,4}};
	row_flip_subsample_sequencer dut (.ref_clk, .resetn, .cfg_addr, .cfg_wr, .cfg_wdata, .cfg_rdata,
		.frame_start, .frame_busy, .frame_done, .row_valid, .row_ready, .row_addr, .row_top_group,
		.row_col_skip, .row_last);
	frame_grabber_model fg (.ref_clk, .resetn, .row_valid, .row_ready, .row_addr, .row_top_group,
		.row_col_skip, .row_last, .stall);
	initial begin
		ref_clk = 0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic end_of_test;
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr = 1;
		@(negedge ref_clk);
		cfg_wr = 0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] exp);
		@(negedge ref_clk);
		cfg_addr = a;
		@(negedge ref_clk);
		check(cfg_rdata, exp);
	endtask
	task automatic frame(input int i);
		int n, kd, b, k;
		kd = tbl[i][0];
		for (k = 2; k < 7; k++)
			wr(k == 6 ? `ADDR_TOTAL_LINES : 7'h40 + k[6:0], tbl[i][k]);
		@(negedge ref_clk);
		frame_start = 1;
		@(negedge ref_clk);
		frame_start = 0;
		if (stall) begin
			// Queue full, so the sequencer must still be busy
			repeat (12) @(negedge ref_clk);
			check(frame_busy, 1);
			wr(`ADDR_FLIP_CTRL, 2);
			frame_start = 1;
			@(negedge ref_clk);
			frame_start = 0;
			stall = 0;
		end
		for (n = 0; n < 200 && (frame_busy !== 0 || row_valid !== 0); n++)
			@(negedge ref_clk);
		if (n == 200) begin
			miscompares++;
			$display("unexpected at %0t: frame hung", $time);
			end_of_test;
		end
		check(fg.rows.size(), tbl[i][6]);
		for (k = 0; k < tbl[i][6]; k++) begin
			b = kd == 0 ? k : kd == 1 ? k * (tbl[i][1] + 1) : k / 2 * (tbl[i][1] + 2) + k % 2;
			b = tbl[i][5] == 2 ? 3071 - b : b;
			check(fg.rows[k], {k == tbl[i][6] - 1, tbl[i][4][1], kd ? k[0] ^ k[1] : k[0], b[11:0]});
		end
		fg.rows.delete();
	endtask
	initial begin
		{resetn, cfg_wr, frame_start, stall, cfg_addr, cfg_wdata} = 0;
		repeat (2) @(negedge ref_clk);
		resetn = 1;
		rd(`ADDR_TOTAL_LINES, `RST_TOTAL_LINES);
		rd(`ADDR_SKIP_OFFSET, `RST_SKIP_OFFSET);
		rd(`ADDR_ROW_STEP, `RST_ROW_STEP);
		rd(`ADDR_MODE_CTRL, `RST_MODE_CTRL);
		rd(`ADDR_FLIP_CTRL, `RST_FLIP_CTRL);
		wr(7'h46, 16'h0003);
		rd(7'h46, 0);
		wr(`ADDR_FLIP_CTRL, 16'hffff);
		rd(`ADDR_FLIP_CTRL, 3);
		for (int i = 0; i < 8; i++) begin
			stall = i == 2;
			frame(i);
		end
		end_of_test;
	end
endmodule // row_flip_subsample_sequencer_bench

// ---- bench/row_seq_checker.sv ----
// Port assertions for the row sequencer
`timescale 1ns/10ps
module row_seq_checker (
	// Clock and reset
	input logic        ref_clk,
	input logic        resetn,
	// Configuration port
	input logic [6:0]  cfg_addr,
	input logic        cfg_wr,
	input logic [15:0] cfg_wdata,
	input logic [15:0] cfg_rdata,
	// Frame and rows
	input logic        frame_start,
	input logic        frame_busy,
	input logic        frame_done,
	input logic        row_valid,
	input logic        row_ready,
	input logic [11:0] row_addr,
	input logic        row_last
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence s_start;
		frame_start && !frame_busy && !row_valid;
	endsequence
	sequence s_first;
		frame_busy ##2 row_valid;
	endsequence
	chk_flip_width: assert property (cfg_addr == 7'h45 |=> cfg_rdata[15:2] == 0)
		else $error("flip field wider than two bits");
	chk_flip_readback: assert property (cfg_wr && cfg_addr == 7'h45 ##1 cfg_addr == 7'h45
		|=> cfg_rdata[1:0] == $past(cfg_wdata[1:0], 2)) else $error("flip readback wrong");
	chk_start_first_row: assert property (s_start |=> s_first)
		else $error("first row late");
	chk_done_pulse: assert property (frame_done |=> !frame_done)
		else $error("done longer than one cycle");
	chk_done_idle: assert property (frame_done |-> !frame_busy)
		else $error("done while busy");
	chk_busy_end: assert property ($fell(frame_busy) && $past(resetn) |-> frame_done)
		else $error("busy ended without done");
	chk_row_hold: assert property (row_valid && !row_ready |=> row_valid && $stable(row_addr)
		&& $stable(row_last)) else $error("row changed while stalled");
	chk_row_range: assert property (row_valid |-> row_addr <= 12'd3071)
		else $error("row beyond array");
endmodule // row_seq_checker
bind row_flip_subsample_sequencer row_seq_checker chk (.ref_clk, .resetn, .cfg_addr, .cfg_wr, .cfg_wdata,
	.cfg_rdata, .frame_start, .frame_busy, .frame_done, .row_valid, .row_ready, .row_addr, .row_last);

// ---- design/row_fifo.v ----
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
module row_fifo #(
	parameter WIDTH = 15,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             ref_clk,
	input  wire             resetn,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	reg             head_valid;

	wire push;
	wire pop_mem;
	wire mem_empty;

	// Head register keeps data outputs from flip-flops
	assign mem_empty = (count == {(AW+1){1'b0}});
	assign in_ready  = (count != DEPTH[AW:0]);
	assign push      = in_valid & in_ready;
	assign out_valid = head_valid;
	assign pop_mem   = ~mem_empty & (~head_valid | out_ready);

	always @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always @(posedge ref_clk) begin
		if (!resetn) begin
			wr_ptr     <= {AW{1'b0}};
			rd_ptr     <= {AW{1'b0}};
			count      <= {(AW+1){1'b0}};
			head_valid <= 1'b0;
			out_data   <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop_mem) begin
				rd_ptr   <= rd_ptr + 1'b1;
				out_data <= mem[rd_ptr];
			end
			if (push & ~pop_mem) begin
				count <= count + 1'b1;
			end else if (pop_mem & ~push) begin
				count <= count - 1'b1;
			end
			if (pop_mem) begin
				head_valid <= 1'b1;
			end else if (out_ready) begin
				head_valid <= 1'b0;
			end
		end
	end

endmodule // row_fifo

// ---- design/row_flip_subsample_sequencer.v ----
// Row readout order generator with vertical flip and subsampling
//
// Notes on behaviour
// - With vertical flip the first row read is physical row 3071 instead of row 0.
// - The flip field reads 0 for no mirroring and 2 for vertical mirroring, and resets to 0.
// - Subsampling combines with any row-windowing setup, so the sequencer places no window limit on it.
// - Monochrome Y subsampling reads one row and then skips an odd count such as 1, 5 or 9.
// - Color Y subsampling reads a row pair and then skips a count such as 2, 6 or 10.
// - X and Y subsampling has a monochrome skip-one scheme and a color skip-two scheme.
// - With subsampling on, rows go to the output groups in remapped readout order.
// - In subsampling the bottom group takes readout rows 1,4,5,8 and the top group rows 2,3,6,7.
`timescale 1ns/10ps
`include "row_seq_consts.vh"
module row_flip_subsample_sequencer (
	// Clock and reset
	input  wire                ref_clk,
	input  wire                resetn,
	// Configuration port
	input  wire [6:0]          cfg_addr,
	input  wire                cfg_wr,
	input  wire [15:0]         cfg_wdata,
	output reg  [15:0]         cfg_rdata,
	// Frame control
	input  wire                frame_start,
	output wire                frame_busy,
	output reg                 frame_done,
	// Row stream toward the readout
	output wire                row_valid,
	input  wire                row_ready,
	output wire [`ROW_W-1:0]   row_addr,
	output wire                row_top_group,
	output wire                row_col_skip,
	output wire                row_last
);

	localparam ST_IDLE = 2'b01;
	localparam ST_RUN  = 2'b10;

	// Software registers
	reg [15:0] total_readout_lines;
	reg [15:0] skip_phase_offset;
	reg [15:0] row_step_size;
	reg [3:0]  subsample_mode_control;
	reg [1:0]  vertical_flip_control;

	// Frame shadows
	reg [15:0] f_lines;
	reg [17:0] f_pair_stride;
	reg [17:0] f_odd_delta;
	reg        f_col_skip;
	reg        f_flip;
	reg        f_sub;

	reg [1:0]  state;
	reg [15:0] line_idx;
	reg [17:0] pair_base;

	wire        q_ready;
	wire        q_valid;
	wire [17:0] log_row;
	wire [17:0] phys_row;
	wire        line_last;
	wire        top_grp;
	wire        push;
	wire [`ENT_W-1:0] q_data;
	wire        sub_on;

	function is_addr;
		input [6:0] a;
		input [6:0] b;
		begin
			is_addr = (a == b);
		end
	endfunction

	// Register writes
	always @(posedge ref_clk) begin
		if (!resetn) begin
			total_readout_lines    <= `RST_TOTAL_LINES;
			skip_phase_offset      <= `RST_SKIP_OFFSET;
			row_step_size          <= `RST_ROW_STEP;
			subsample_mode_control <= `RST_MODE_CTRL;
			vertical_flip_control  <= `RST_FLIP_CTRL;
		end else if (cfg_wr) begin
			if (is_addr(cfg_addr, `ADDR_TOTAL_LINES)) begin
				total_readout_lines <= cfg_wdata;
			end
			if (is_addr(cfg_addr, `ADDR_SKIP_OFFSET)) begin
				skip_phase_offset <= cfg_wdata;
			end
			if (is_addr(cfg_addr, `ADDR_ROW_STEP)) begin
				row_step_size <= cfg_wdata;
			end
			if (is_addr(cfg_addr, `ADDR_MODE_CTRL)) begin
				subsample_mode_control <= cfg_wdata[3:0];
			end
			if (is_addr(cfg_addr, `ADDR_FLIP_CTRL)) begin
				vertical_flip_control <= cfg_wdata[1:0];
			end
		end
	end

	// Register reads, unmapped addresses read zero
	always @(posedge ref_clk) begin
		if (!resetn) begin
			cfg_rdata <= 16'h0000;
		end else begin
			case (cfg_addr)
				`ADDR_TOTAL_LINES: cfg_rdata <= total_readout_lines;
				`ADDR_SKIP_OFFSET: cfg_rdata <= skip_phase_offset;
				`ADDR_ROW_STEP:    cfg_rdata <= row_step_size;
				`ADDR_MODE_CTRL:   cfg_rdata <= {12'h000, subsample_mode_control};
				`ADDR_FLIP_CTRL:   cfg_rdata <= {14'h0000, vertical_flip_control};
				default:           cfg_rdata <= 16'h0000;
			endcase
		end
	end

	// Row of the current line counted from the frame start edge
	assign log_row   = pair_base + (line_idx[0] ? f_odd_delta : 18'h00000);
	// Flip reverses the order so line 0 lands on the last row
	assign phys_row  = f_flip ? (`LAST_ROW - log_row) : log_row;
	// A line past the array edge ends the frame early; plain readout counts beyond 3072 are clipped this way
	assign line_last = ((line_idx + 16'h0001) == f_lines) ||
	                   ((pair_base + f_pair_stride) > `LAST_ROW && line_idx[0]) ||
	                   ((pair_base + f_odd_delta) > `LAST_ROW && !line_idx[0]) ||
	                   (log_row >= `LAST_ROW);
	// With subsampling, bottom on readout rows 1,4,5,8 and top on 2,3,6,7; plain readout puts top on 2,4,6,8
	assign top_grp   = f_sub ? (line_idx[0] ^ line_idx[1]) : line_idx[0];
	assign push      = (state == ST_RUN) & q_ready;
	assign q_valid   = (state == ST_RUN);
	assign q_data    = {line_last, f_col_skip, top_grp, phys_row[`ROW_W-1:0]};
	assign frame_busy = (state == ST_RUN);
	// Plain readout leaves offset at zero, so subsampling is keyed on step and column skip
	assign sub_on    = subsample_mode_control[`MODE_COLSKIP_BIT] | (row_step_size != `RST_ROW_STEP);

	always @(posedge ref_clk) begin
		if (!resetn) begin
			state         <= ST_IDLE;
			line_idx      <= 16'h0000;
			pair_base     <= 18'h00000;
			f_lines       <= `RST_TOTAL_LINES;
			f_pair_stride <= 18'h00002;
			f_odd_delta   <= 18'h00001;
			f_col_skip    <= 1'b0;
			f_flip        <= 1'b0;
			f_sub         <= 1'b0;
			frame_done    <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (frame_start) begin
						// Settings are sampled once so a frame never mixes two configurations
						f_lines       <= (total_readout_lines == 16'h0000) ? 16'h0001
						                 : total_readout_lines;
						f_pair_stride <= {1'b0, row_step_size, 1'b0};
						// Color and plain readout keep adjacent rows; mono subsampling spaces the odd line
						f_odd_delta   <= (subsample_mode_control[`MODE_MONO_BIT] & sub_on)
						                 ? {1'b0, skip_phase_offset, 1'b0} : 18'h00001;
						f_col_skip    <= subsample_mode_control[`MODE_COLSKIP_BIT];
						f_flip        <= (vertical_flip_control == `FLIP_Y);
						// Window setup is not checked, any window layout may be subsampled
						f_sub         <= sub_on;
						line_idx      <= 16'h0000;
						pair_base     <= 18'h00000;
						state         <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (push) begin
						if (line_last) begin
							state      <= ST_IDLE;
							frame_done <= 1'b1;
						end else begin
							line_idx <= line_idx + 16'h0001;
							if (line_idx[0]) begin
								pair_base <= pair_base + f_pair_stride;
							end
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	wire [`ENT_W-1:0] out_ent;

	// The readout can stall; a full queue holds the sequencer in place
	row_fifo #(
		.WIDTH (`ENT_W),
		.DEPTH (`QUEUE_DEPTH),
		.AW    (3)
	) u_queue (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.in_valid  (q_valid),
		.in_ready  (q_ready),
		.in_data   (q_data),
		.out_valid (row_valid),
		.out_ready (row_ready),
		.out_data  (out_ent)
	);

	assign row_addr      = out_ent[`ROW_W-1:0];
	assign row_top_group = out_ent[`ENT_TOP_BIT];
	assign row_col_skip  = out_ent[`ENT_COLSKIP_BIT];
	assign row_last      = out_ent[`ENT_LAST_BIT];

endmodule // row_flip_subsample_sequencer

// ---- design/row_seq_consts.vh ----
// Constants for the row flip and subsample sequencer
`ifndef ROW_SEQ_CONSTS_VH
`define ROW_SEQ_CONSTS_VH

// Register addresses on the configuration port
`define ADDR_TOTAL_LINES   7'h01
`define ADDR_SKIP_OFFSET   7'h42
`define ADDR_ROW_STEP      7'h43
`define ADDR_MODE_CTRL     7'h44
`define ADDR_FLIP_CTRL     7'h45

// Reset values
`define RST_TOTAL_LINES    16'h0c00
`define RST_SKIP_OFFSET    16'h0000
`define RST_ROW_STEP       16'h0001
`define RST_MODE_CTRL      4'h9
`define RST_FLIP_CTRL      2'h0

// Mode register fields
`define MODE_MONO_BIT      0
`define MODE_COLSKIP_BIT   1
`define MODE_MONO_EXP_BIT  3

// Flip field encodings
`define FLIP_NONE          2'h0
`define FLIP_Y             2'h2

// Array geometry
`define LAST_ROW           18'h00bff
`define ROW_W              12

// Queue entry layout
`define ENT_W              15
`define ENT_LAST_BIT       14
`define ENT_COLSKIP_BIT    13
`define ENT_TOP_BIT        12

`define QUEUE_DEPTH        8

`endif
